// ### rxd_pkg.sv
// Shared constants and types for the serial receive data recovery block
package rxd_pkg;

  // ****************************************
  // Sample tick positions within one bit
  // ****************************************
  localparam int unsigned RT_W = 5;
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_SECOND = 5'h02;
  localparam logic [4:0] RT_VER_A = 5'h03;
  localparam logic [4:0] RT_VER_B = 5'h05;
  localparam logic [4:0] RT_VER_C = 5'h07;
  localparam logic [4:0] RT_VOTE_A = 5'h08;
  localparam logic [4:0] RT_VOTE_B = 5'h09;
  localparam logic [4:0] RT_VOTE_C = 5'h0A;
  localparam logic [4:0] RT_LAST = 5'h10;

  // ****************************************
  // Character and idle geometry
  // ****************************************
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
  localparam logic [2:0] HIST_ONES = 3'h7;

  // ****************************************
  // Buffered word layout, buffer depth and divider width
  // ****************************************
  localparam int unsigned DATA_W = 9;
  localparam int unsigned WORD_W = 11;
  localparam int unsigned FW_FE = 9;
  localparam int unsigned FW_NF = 10;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned DIV_W = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] RT_RST = 5'h00;
  localparam logic [8:0] DATA_RST = 9'h000;
  localparam logic [7:0] IDLE_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;

  typedef enum logic [1:0] {
    RXD_SEARCH = 2'b00,
    RXD_START = 2'b01,
    RXD_DATA = 2'b10,
    RXD_STOP = 2'b11
  } rxd_state_t;

endpackage : rxd_pkg

// ### rxd_receiver.sv
// Receive data recovery: oversampling, start search, voting, wakeup and output buffer
`timescale 1ns/1ps


// ****************************************
// Buffer between recovery and reader
// ****************************************
module rxd_fifo #(
  parameter int unsigned WIDTH = rxd_pkg::WORD_W,
  parameter int unsigned DEPTH = rxd_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_reg != FULL_CNT);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule : rxd_fifo

// ****************************************
// Receiver top
// ****************************************
module rxd_receiver #(
  parameter int unsigned FIFO_DEPTH = rxd_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_receive_input_i,
  input wire logic [15:0] tick_div_i,
  input wire logic char_len_9_i,
  input wire logic wake_addr_mark_i,
  input wire logic idle_count_start_select_i,
  input wire logic standby_set_i,
  input wire logic flag_clear_i,
  input wire logic read_ack_i,
  output logic [8:0] rx_data_o,
  output logic receive_full_flag_o,
  output logic framing_error_flag_o,
  output logic noise_flag_o,
  output logic idle_flag_o,
  output logic overrun_flag_o,
  output logic receiver_standby_bit_o,
  output logic rx_request_o
);

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'h0) && (s != 3'h7);
  endfunction : split3

  // ****************************************
  // Input synchronizer and sample tick
  // ****************************************
  logic sync1_reg;
  logic sync2_reg;
  logic [15:0] div_reg;
  logic tick_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= serial_receive_input_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Tick every tick_div_i+1 clocks, programmed to sixteen per bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= rxd_pkg::DIV_RST;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == tick_div_i);
      div_reg <= (div_reg == tick_div_i) ? rxd_pkg::DIV_RST : div_reg + 1'b1;
    end
  end

  // ****************************************
  // Recovery state machine
  // ****************************************
  rxd_pkg::rxd_state_t state_reg;
  logic [4:0] rt_reg;
  logic [2:0] hist_reg;
  logic [1:0] samp_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic last_bit_reg;
  logic nz_pend_reg;
  logic comp_reg;
  logic comp_fe_reg;
  logic comp_nf_reg;

  wire rx_s = sync2_reg;
  wire [2:0] win3 = {samp_reg, rx_s};
  wire [1:0] ver_ones = 2'(win3[0]) + 2'(win3[1]) + 2'(win3[2]);
  wire [3:0] nbits = char_len_9_i ? rxd_pkg::DATA_BITS_9 : rxd_pkg::DATA_BITS_8;
  wire start_det = !rx_s && (hist_reg == rxd_pkg::HIST_ONES);
  wire in_char = (state_reg == rxd_pkg::RXD_DATA) || (state_reg == rxd_pkg::RXD_STOP);
  wire fall_ok = in_char && !rx_s && hist_reg[0] && last_bit_reg;
  wire resync_early = fall_ok && (rt_reg < rxd_pkg::RT_VOTE_A);
  wire resync_late = fall_ok && (rt_reg > rxd_pkg::RT_VOTE_C);
  wire bit_end = (rt_reg == rxd_pkg::RT_LAST) || resync_late;
  wire take_a = (rt_reg == rxd_pkg::RT_VER_A) || (rt_reg == rxd_pkg::RT_VER_B)
    || (rt_reg == rxd_pkg::RT_VOTE_A) || (rt_reg == rxd_pkg::RT_VOTE_B);
  wire rt_next_wrap = (rt_reg == rxd_pkg::RT_LAST);
  wire vote = maj3(win3);
  wire at_vote = (rt_reg == rxd_pkg::RT_VOTE_C);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_reg <= 3'h0;
      samp_reg <= 2'h0;
    end else if (tick_reg) begin
      hist_reg <= {hist_reg[1:0], rx_s};
      if (take_a) samp_reg <= {samp_reg[0], rx_s};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= rxd_pkg::RXD_SEARCH;
      rt_reg <= rxd_pkg::RT_RST;
      bit_cnt_reg <= 4'h0;
      shift_reg <= rxd_pkg::DATA_RST;
      last_bit_reg <= 1'b0;
      nz_pend_reg <= 1'b0;
      comp_reg <= 1'b0;
      comp_fe_reg <= 1'b0;
      comp_nf_reg <= 1'b0;
    end else begin
      comp_reg <= 1'b0;
      if (tick_reg) begin
        rt_reg <= rt_next_wrap ? rxd_pkg::RT_FIRST : rt_reg + 1'b1;
        unique case (state_reg)
          rxd_pkg::RXD_SEARCH: begin
            rt_reg <= rxd_pkg::RT_RST;
            if (start_det) begin
              state_reg <= rxd_pkg::RXD_START;
              rt_reg <= rxd_pkg::RT_SECOND;
              nz_pend_reg <= 1'b0;
            end
          end
          rxd_pkg::RXD_START: begin
            if (rt_reg == rxd_pkg::RT_VER_C) begin
              if (ver_ones[1]) begin
                state_reg <= rxd_pkg::RXD_SEARCH;
                rt_reg <= rxd_pkg::RT_RST;
              end else if (ver_ones[0]) begin
                nz_pend_reg <= 1'b1;
              end
            end
            // Late start samples only add noise, never reject
            if (rx_s && (rt_reg >= rxd_pkg::RT_VOTE_A) && (rt_reg <= rxd_pkg::RT_VOTE_C)) begin
              nz_pend_reg <= 1'b1;
            end
            if (rt_next_wrap) begin
              state_reg <= rxd_pkg::RXD_DATA;
              bit_cnt_reg <= 4'h0;
              last_bit_reg <= 1'b0;
            end
          end
          rxd_pkg::RXD_DATA: begin
            if (at_vote) begin
              shift_reg <= {vote, shift_reg[8:1]};
              last_bit_reg <= vote;
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              if (split3(win3)) nz_pend_reg <= 1'b1;
            end
            if (resync_early || resync_late) rt_reg <= rxd_pkg::RT_SECOND;
            if (bit_end && (bit_cnt_reg == nbits)) state_reg <= rxd_pkg::RXD_STOP;
          end
          rxd_pkg::RXD_STOP: begin
            if (resync_early) rt_reg <= rxd_pkg::RT_SECOND;
            // Finish at tick 10 so a fast stop bit is never cut short
            if (at_vote) begin
              comp_reg <= 1'b1;
              comp_fe_reg <= !vote;
              comp_nf_reg <= nz_pend_reg || split3(win3);
              state_reg <= rxd_pkg::RXD_SEARCH;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Idle detection and standby
  // ****************************************
  logic [7:0] idle_cnt_reg;
  logic idle_prev_reg;
  logic standby_reg;

  wire [7:0] idle_lim = char_len_9_i ? rxd_pkg::IDLE_TICKS_9 : rxd_pkg::IDLE_TICKS_8;
  // Counting after the start bit may see trailing data ones as idle
  wire idle_en = idle_count_start_select_i ? (state_reg == rxd_pkg::RXD_SEARCH)
    : (state_reg != rxd_pkg::RXD_START);
  wire idle_level = (idle_cnt_reg == idle_lim);
  wire idle_rise = idle_level && !idle_prev_reg;
  // Last data bit lands in bit 8 for either length
  wire char_msb = shift_reg[8];
  wire addr_wake = comp_reg && standby_reg && wake_addr_mark_i && char_msb;
  wire idle_wake = standby_reg && !wake_addr_mark_i && idle_level;
  wire [8:0] char_data = char_len_9_i ? shift_reg : {1'b0, shift_reg[8:1]};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_cnt_reg <= rxd_pkg::IDLE_RST;
    end else if (tick_reg) begin
      if (!rx_s || !idle_en) idle_cnt_reg <= rxd_pkg::IDLE_RST;
      else if (!idle_level) idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  // Software entry wins; a still idle line then wakes on the next cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_prev_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else begin
      idle_prev_reg <= idle_level;
      if (standby_set_i) standby_reg <= 1'b1;
      else if (addr_wake || idle_wake) standby_reg <= 1'b0;
    end
  end

  // ****************************************
  // Character buffer and read side
  // ****************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [rxd_pkg::WORD_W-1:0] fifo_out_data;
  logic out_valid_reg;
  logic [8:0] out_data_reg;
  logic fe_reg;
  logic nf_reg;
  logic idle_flag_reg;
  logic overrun_reg;
  logic req_reg;

  // Discarded while asleep, unless it is the waking address mark
  wire push = comp_reg && (!standby_reg || addr_wake);
  wire load = fifo_out_valid && (!out_valid_reg || read_ack_i);
  wire [rxd_pkg::WORD_W-1:0] push_word = {comp_nf_reg, comp_fe_reg, char_data};

  rxd_fifo #(
    .WIDTH(rxd_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(load),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= rxd_pkg::DATA_RST;
    end else if (load) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= fifo_out_data[rxd_pkg::DATA_W-1:0];
    end else if (read_ack_i) begin
      out_valid_reg <= 1'b0;
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fe_reg <= 1'b0;
      nf_reg <= 1'b0;
      idle_flag_reg <= 1'b0;
      overrun_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      fe_reg <= (load && fifo_out_data[rxd_pkg::FW_FE]) || (fe_reg && !flag_clear_i);
      nf_reg <= (load && fifo_out_data[rxd_pkg::FW_NF]) || (nf_reg && !flag_clear_i);
      idle_flag_reg <= (idle_rise && !standby_reg) || (idle_flag_reg && !flag_clear_i);
      overrun_reg <= (push && !fifo_in_ready) || (overrun_reg && !flag_clear_i);
      req_reg <= !standby_reg && (out_valid_reg || idle_flag_reg || fe_reg || nf_reg);
    end
  end

  assign rx_data_o = out_data_reg;
  assign receive_full_flag_o = out_valid_reg;
  assign framing_error_flag_o = fe_reg;
  assign noise_flag_o = nf_reg;
  assign idle_flag_o = idle_flag_reg;
  assign overrun_flag_o = overrun_reg;
  assign receiver_standby_bit_o = standby_reg;
  assign rx_request_o = req_reg;

endmodule : rxd_receiver

// ### rxd_receiver_assertions.sv
// Concurrent checks on the ports of the serial receive data recovery block
`timescale 1ns/1ps
module rxd_receiver_checker #(
  parameter int unsigned FIFO_DEPTH = rxd_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic char_len_9_i,
  input wire logic wake_addr_mark_i,
  input wire logic standby_set_i,
  input wire logic flag_clear_i,
  input wire logic read_ack_i,
  input wire logic [8:0] rx_data_o,
  input wire logic receive_full_flag_o,
  input wire logic framing_error_flag_o,
  input wire logic noise_flag_o,
  input wire logic receiver_standby_bit_o,
  input wire logic rx_request_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_fe_rise;
    $rose(framing_error_flag_o);
  endsequence
  // Wake by address mark: standby drops while that method is selected
  sequence s_mark_wake;
    $fell(receiver_standby_bit_o) ##0 wake_addr_mark_i;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  AST_FE_WITH_FULL: assert property (s_fe_rise |-> receive_full_flag_o)
    else $error("framing error rose without receive full");
  AST_NF_WITH_FULL: assert property ($rose(noise_flag_o) |-> receive_full_flag_o)
    else $error("noise flag rose without receive full");
  AST_FE_STICKY: assert property (framing_error_flag_o && !flag_clear_i |=> framing_error_flag_o)
    else $error("framing error dropped without clear");
  AST_NF_STICKY: assert property (noise_flag_o && !flag_clear_i |=> noise_flag_o)
    else $error("noise flag dropped without clear");
  AST_FULL_STANDS: assert property (receive_full_flag_o && !read_ack_i |=> receive_full_flag_o && $stable(rx_data_o))
    else $error("presented character changed before read");
  AST_STANDBY_ENTRY: assert property (standby_set_i |=> receiver_standby_bit_o)
    else $error("standby not entered");
  AST_STANDBY_QUIET: assert property (receiver_standby_bit_o |=> !rx_request_o)
    else $error("request raised in standby");
  AST_BYTE_TOP_ZERO: assert property ($rose(receive_full_flag_o) && !char_len_9_i |-> !rx_data_o[8])
    else $error("ninth bit set in 8-bit mode");
  AST_MARK_WAKE_FULL: assert property (s_mark_wake |-> ##[0:6] receive_full_flag_o)
    else $error("address mark wake without receive full");
  AST_IDLE_WAKE_EMPTY: assert property ($fell(receiver_standby_bit_o) && !wake_addr_mark_i && !receive_full_flag_o
    |=> !receive_full_flag_o)
    else $error("idle wake set receive full");
endmodule : rxd_receiver_checker

bind rxd_receiver rxd_receiver_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .char_len_9_i(char_len_9_i), .wake_addr_mark_i(wake_addr_mark_i), .standby_set_i(standby_set_i),
  .flag_clear_i(flag_clear_i), .read_ack_i(read_ack_i), .rx_data_o(rx_data_o),
  .receive_full_flag_o(receive_full_flag_o), .framing_error_flag_o(framing_error_flag_o),
  .noise_flag_o(noise_flag_o), .receiver_standby_bit_o(receiver_standby_bit_o), .rx_request_o(rx_request_o));

// ### rxd_tx_model.sv
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/1ps
module rxd_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  // First clock of the two-clock inverted span within the glitched bit
  int glitch_at = 16;
  initial line_o = 1'b1;
  // ****************************************
  // Frame driver
  // ****************************************
  // Bit time in clocks sets slow or fast data; gi inverts one sample span of that bit
  task automatic send(input logic [8:0] d, input int nbits, input int bclk, input logic stop, input int gi);
    logic v;
    repeat (3 * bclk) @(negedge clk_i) line_o <= 1'b1;
    for (int b = 0; b <= nbits + 1; b++) begin
      v = (b == 0) ? 1'b0 : (b <= nbits) ? d[b-1] : stop;
      for (int c = 0; c < bclk; c++) begin
        @(negedge clk_i);
        line_o <= v ^ logic'(b == gi && c >= glitch_at && c < glitch_at + 2);
      end
    end
    @(negedge clk_i) line_o <= 1'b1;
  endtask : send
  task automatic pulse(input int clks);
    repeat (clks) @(negedge clk_i) line_o <= 1'b0;
    @(negedge clk_i) line_o <= 1'b1;
  endtask : pulse
endmodule : rxd_tx_model

// ### rxd_receiver_tb_top.sv
// Self-checking testbench of the serial receive data recovery block
`timescale 1ns/1ps
module rxd_receiver_tb_top;
  typedef struct packed {
    logic [8:0] d;
    logic fe;
    logic nf;
  } rxd_note_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic serial_receive_input_i;
  logic char_len_9_i = 1'b0;
  logic wake_addr_mark_i = 1'b0;
  logic idle_count_start_select_i = 1'b0;
  logic standby_set_i = 1'b0;
  logic flag_clear_i = 1'b0;
  logic read_ack_i = 1'b0;
  logic [8:0] rx_data_o;
  logic receive_full_flag_o;
  logic framing_error_flag_o;
  logic noise_flag_o;
  logic idle_flag_o;
  logic overrun_flag_o;
  logic receiver_standby_bit_o;
  logic rx_request_o;
  logic ack_en = 1'b1;
  logic [31:0] seed = 32'h00000F76;
  logic [8:0] d;
  rxd_note_t notes[$];
  rxd_note_t n;
  int fail_count = 0;
  int checks_done = 0;
  // Two clocks per tick keeps 32 clocks per bit
  rxd_receiver #(.FIFO_DEPTH(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .serial_receive_input_i(serial_receive_input_i), .tick_div_i(16'h0001), .char_len_9_i(char_len_9_i),
    .wake_addr_mark_i(wake_addr_mark_i), .idle_count_start_select_i(idle_count_start_select_i),
    .standby_set_i(standby_set_i), .flag_clear_i(flag_clear_i), .read_ack_i(read_ack_i), .rx_data_o(rx_data_o),
    .receive_full_flag_o(receive_full_flag_o), .framing_error_flag_o(framing_error_flag_o),
    .noise_flag_o(noise_flag_o), .idle_flag_o(idle_flag_o), .overrun_flag_o(overrun_flag_o),
    .receiver_standby_bit_o(receiver_standby_bit_o), .rx_request_o(rx_request_o));
  rxd_tx_model u_tx (.clk_i(clk_i), .line_o(serial_receive_input_i));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic mismatch(input string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : mismatch
  task automatic check(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) mismatch(msg);
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic send_exp(input logic [8:0] dv, input int bc, input logic stop, input int gi, input logic nf);
    notes.push_back({dv, ~stop, nf});
    u_tx.send(dv, char_len_9_i ? 9 : 8, bc, stop, gi);
  endtask : send_exp
  task automatic drain_clear();
    for (int i = 0; i < 3000 && notes.size() != 0; i++) @(negedge clk_i);
    checks_done++;
    if (notes.size() != 0) mismatch("character missing");
    @(negedge clk_i);
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    flag_clear_i = 1'b0;
  endtask : drain_clear
  task automatic pulse_standby();
    @(negedge clk_i);
    standby_set_i = 1'b1;
    @(negedge clk_i);
    standby_set_i = 1'b0;
  endtask : pulse_standby
  // ****************************************
  // Reader and monitor
  // ****************************************
  // Random stalls on the read side let the buffer back up
  always @(negedge clk_i) begin
    seed <= xs(seed);
    read_ack_i <= ack_en && receive_full_flag_o && seed[2];
  end
  always @(posedge clk_i) begin
    if (read_ack_i && receive_full_flag_o) begin
      checks_done++;
      if (notes.size() == 0) mismatch("unexpected character");
      else begin
        n = notes.pop_front();
        if ({rx_data_o, framing_error_flag_o, noise_flag_o} !== n) mismatch("character or flags differ");
      end
    end
  end
  // ****************************************
  // Clock, watchdog, sequence
  // ****************************************
  initial forever #2 clk_i = ~clk_i;
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatch("watchdog expired");
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i) rst_n_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      char_len_9_i = m[0];
      idle_count_start_select_i = m[0];
      for (int k = 0; k < 6; k++) begin
        d = {m[0] & seed[8], seed[7:0]};
        send_exp(d, 31 + k % 3, 1'b1, -1, 1'b0);
      end
      drain_clear();
    end
    char_len_9_i = 1'b0;
    send_exp(9'h0A5, 32, 1'b0, -1, 1'b0);
    drain_clear();
    send_exp(9'h000, 32, 1'b0, -1, 1'b0);
    drain_clear();
    // Glitch on start tick 9, data bit 0, stop bit, then on start tick 5
    for (int g = 0; g < 4; g++) begin
      u_tx.glitch_at = (g == 3) ? 8 : 16;
      send_exp(9'h03C, 32, 1'b1, (g == 2) ? 9 : g % 3, 1'b1);
      drain_clear();
    end
    u_tx.pulse(4);
    repeat (200) @(negedge clk_i);
    send_exp(9'h0C3, 32, 1'b1, -1, 1'b0);
    drain_clear();
    wake_addr_mark_i = 1'b1;
    pulse_standby();
    check(receiver_standby_bit_o, 1'b1, "standby not entered");
    u_tx.send(9'h012, 8, 32, 1'b1, -1);
    repeat (20) @(negedge clk_i);
    check(receive_full_flag_o, 1'b0, "character taken in standby");
    send_exp(9'h09A, 32, 1'b1, -1, 1'b0);
    drain_clear();
    check(receiver_standby_bit_o, 1'b0, "address mark did not wake");
    pulse_standby();
    u_tx.send(9'h044, 8, 32, 1'b1, -1);
    repeat (20) @(negedge clk_i);
    check(receive_full_flag_o, 1'b0, "character taken after re-entering standby");
    wake_addr_mark_i = 1'b0;
    for (int i = 0; i < 1000 && receiver_standby_bit_o !== 1'b0; i++) @(negedge clk_i);
    check(receiver_standby_bit_o, 1'b0, "idle line did not wake");
    check(receive_full_flag_o, 1'b0, "idle wake set receive full");
    check(idle_flag_o, 1'b0, "waking idle set idle flag");
    ack_en = 1'b0;
    for (int k = 0; k < 20; k++) begin
      d = {1'b0, seed[7:0]};
      // Buffer plus the presented word hold seventeen characters
      if (k < 17) notes.push_back({d, 1'b0, 1'b0});
      u_tx.send(d, 8, 32, 1'b1, -1);
    end
    repeat (20) @(negedge clk_i);
    check(overrun_flag_o, 1'b1, "overrun not flagged");
    ack_en = 1'b1;
    for (int i = 0; i < 3000 && notes.size() != 0; i++) @(negedge clk_i);
    repeat (8) @(negedge clk_i);
    check(receive_full_flag_o, 1'b0, "extra character after overrun");
    drain_clear();
    // Idle flag must wait for a full idle span after the character
    for (int s = 0; s < 2; s++) begin
      idle_count_start_select_i = s[0];
      send_exp(9'h055, 32, 1'b1, -1, 1'b0);
      drain_clear();
      check(idle_flag_o, 1'b0, "idle flagged too early");
      repeat (400) @(negedge clk_i);
      check(idle_flag_o, 1'b1, "idle line not flagged");
      check(rx_request_o, 1'b1, "no request for idle line");
    end
    give_verdict();
  end
endmodule : rxd_receiver_tb_top
